// ---- verilog/cmp_ctrl.v ----
// Digital control, output conditioning and edge flagging for one analog comparator
`timescale 1ns/1ns
`include "cmp_ctrl_consts.vh"
//Contract
// - Comparator runs only while on bit set
// - Disabled comparator disconnects all input sources
// - Disabled raw output forced to zero
// - Reported output is raw XOR invert
// - Output readable in control and mirror
// - Internal output registered each instruction cycle
// - Hysteresis bit drives analog hysteresis control
// - Output offered as odd-timer gate source
// - Sync captures on falling timer clock edge
// - Sync uses prescaled timer clock if enabled
// - Sync clear passes output through unlatched
// - Enabled rise/fall edges set interrupt flag
// - Edges judged on polarity-adjusted output
// - Software clears flag; set wins clear
// - Invert or on toggles can raise edges
// - Plus selector decode per code table
// - Minus selector decode per code table
// - Active output suspends waveform gen if enabled
// - Rising output triggers conversion when selected
// - Rising output resets even timer when selected
// - Works in sleep; sync stops on sysclk timer
// - Enabled edge event wakes device from sleep
module cmp_ctrl (
    // APB slave
    input  wire                pclk,
    input  wire                presetn,
    input  wire                psel,
    input  wire                penable,
    input  wire                pwrite,
    input  wire [11:0]         paddr,
    input  wire [31:0]         pwdata,
    output reg  [31:0]         prdata,
    output reg                 pready,
    output reg                 pslverr,
    // Analog core
    input  wire                analog_raw,
    output reg                 analog_on,
    output reg                 hysteresis_on,
    output reg  [`SRC_W-1:0]   plus_src_on,
    output reg  [`SRC_W-1:0]   minus_src_on,
    // Timer clock (pin, asynchronous) and prescaled version
    input  wire                timer_clk_in,
    input  wire                timer_clk_pre_in,
    // Outputs to consumers
    output reg                 gate_out,
    output reg                 pin_out,
    output reg                 conv_trigger,
    output reg                 even_timer_reset,
    output reg                 waveform_shutdown,
    output reg                 cmp_irq_flag,
    output reg                 wake_req
);

    reg        cmp_on_r;
    reg        invert_select_r;
    reg        hyst_r;
    reg        sync_r;
    reg        rise_irq_on_r;
    reg        fall_irq_on_r;
    reg [2:0]  plus_input_sel_r;
    reg [2:0]  minus_input_sel_r;
    reg [5:0]  sys_ctrl_r;
    reg        cmp_result_bit_r;
    reg        result_prev_r;
    reg        flag_r;
    reg [2:0]  raw_sync_r;
    reg [2:0]  tclk_sync_r;
    reg [2:0]  tpre_sync_r;
    reg        raw_stable_r;
    reg        tclk_stable_r;
    reg        sync_hold_r;
    reg [31:0] rdata_nxt;
    reg        slverr_nxt;

    wire wr_acc = psel & penable & pwrite;
    wire rd_setup = psel & ~penable & ~pwrite;
    wire wr_setup = psel & ~penable & pwrite;
    wire flag_clr = wr_acc & (paddr == `OFF_IRQ_FLAG) & pwdata[0];

    // Separate plus and minus selector decodes; off disconnects everything
    function [`SRC_W-1:0] plus_decode;
        input [2:0] sel;
        input       on;
        begin
            plus_decode = {`SRC_W{1'b0}};
            if (on) begin
                case (sel)
                    `PSEL_PIN0: plus_decode[`SRC_PIN0] = 1'b1;
                    `PSEL_PIN1: plus_decode[`SRC_PIN0+1] = 1'b1;
                    `PSEL_DAC:  plus_decode[`SRC_DAC] = 1'b1;
                    `PSEL_REF2: plus_decode[`SRC_REF2] = 1'b1;
                    `PSEL_GND:  plus_decode[`SRC_GND] = 1'b1;
                    default:    plus_decode = {`SRC_W{1'b0}};
                endcase
            end
        end
    endfunction

    function [`SRC_W-1:0] minus_decode;
        input [2:0] sel;
        input       on;
        begin
            minus_decode = {`SRC_W{1'b0}};
            if (on) begin
                case (sel)
                    `NSEL_PIN0: minus_decode[`SRC_PIN0] = 1'b1;
                    `NSEL_PIN1: minus_decode[`SRC_PIN0+1] = 1'b1;
                    `NSEL_PIN2: minus_decode[`SRC_PIN0+2] = 1'b1;
                    `NSEL_PIN3: minus_decode[`SRC_PIN0+3] = 1'b1;
                    `NSEL_REF2: minus_decode[`SRC_REF2] = 1'b1;
                    `NSEL_GND:  minus_decode[`SRC_GND] = 1'b1;
                    default:    minus_decode = {`SRC_W{1'b0}};
                endcase
            end
        end
    endfunction

    // Raw comparison is gated by the on bit before inversion
    wire raw_gated = raw_stable_r & cmp_on_r;
    wire result_now = raw_gated ^ invert_select_r;

    // Timer clock selection: prescaled clock when prescaler is used
    wire use_pre = sys_ctrl_r[`SC_PRESCALE_BIT];
    wire tclk_fall = use_pre ? (tpre_sync_r[2] & ~tpre_sync_r[1])
                             : (tclk_sync_r[2] & ~tclk_sync_r[1]);
    // A system-clock timer halts in sleep, so the synced path freezes
    wire sync_stall = sys_ctrl_r[`SC_SLEEP_BIT] & sys_ctrl_r[`SC_TMR_SYSCLK_BIT];

    wire rise_evt = result_now & ~result_prev_r;
    wire fall_evt = ~result_now & result_prev_r;
    wire irq_evt = (rise_evt & rise_irq_on_r) | (fall_evt & fall_irq_on_r);

    // Input synchronisers; raw and timer clock changes accepted once stages two and three agree (prescaled clock unfiltered)
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_sync_r    <= 3'h0;
            tclk_sync_r   <= 3'h0;
            tpre_sync_r   <= 3'h0;
            raw_stable_r  <= 1'b0;
            tclk_stable_r <= 1'b0;
        end else begin
            raw_sync_r  <= {raw_sync_r[1:0], analog_raw};
            tclk_sync_r <= {tclk_sync_r[1:0], timer_clk_in};
            tpre_sync_r <= {tpre_sync_r[1:0], timer_clk_pre_in};
            if (raw_sync_r[1] == raw_sync_r[2])
                raw_stable_r <= raw_sync_r[2];
            if (tclk_sync_r[1] == tclk_sync_r[2])
                tclk_stable_r <= tclk_sync_r[2];
        end
    end

    // Control registers and APB slave, zero wait states
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_on_r          <= 1'b0;
            invert_select_r   <= 1'b0;
            hyst_r            <= 1'b0;
            sync_r            <= 1'b0;
            rise_irq_on_r     <= 1'b0;
            fall_irq_on_r     <= 1'b0;
            plus_input_sel_r  <= `SEL_RST;
            minus_input_sel_r <= `SEL_RST;
            sys_ctrl_r        <= `SYS_CTRL_RST;
            prdata            <= 32'h0;
            pready            <= 1'b0;
            pslverr           <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            prdata  <= rd_setup ? rdata_nxt : 32'h0;
            pslverr <= (psel & ~penable) & slverr_nxt;
            if (wr_acc) begin
                case (paddr)
                    `OFF_CTRL_A: begin
                        cmp_on_r        <= pwdata[`CA_ON_BIT];
                        invert_select_r <= pwdata[`CA_INVERT_BIT];
                        hyst_r          <= pwdata[`CA_HYST_BIT];
                        sync_r          <= pwdata[`CA_SYNC_BIT];
                    end
                    `OFF_CTRL_B: begin
                        rise_irq_on_r <= pwdata[`CB_RISE_BIT];
                        fall_irq_on_r <= pwdata[`CB_FALL_BIT];
                    end
                    `OFF_MINUS_SEL: minus_input_sel_r <= pwdata[2:0];
                    `OFF_PLUS_SEL:  plus_input_sel_r  <= pwdata[2:0];
                    `OFF_SYS_CTRL:  sys_ctrl_r        <= pwdata[5:0];
                    default: ;
                endcase
            end
        end
    end

    // Read mux; unmapped addresses answer with an error
    always @* begin
        rdata_nxt  = 32'h0;
        slverr_nxt = 1'b0;
        case (paddr)
            `OFF_CTRL_A: begin
                rdata_nxt[`CA_ON_BIT]     = cmp_on_r;
                rdata_nxt[`CA_RESULT_BIT] = cmp_result_bit_r;
                rdata_nxt[`CA_INVERT_BIT] = invert_select_r;
                rdata_nxt[`CA_HYST_BIT]   = hyst_r;
                rdata_nxt[`CA_SYNC_BIT]   = sync_r;
            end
            `OFF_CTRL_B:        rdata_nxt[1:0] = {rise_irq_on_r, fall_irq_on_r};
            `OFF_MINUS_SEL:     rdata_nxt[2:0] = minus_input_sel_r;
            `OFF_PLUS_SEL:      rdata_nxt[2:0] = plus_input_sel_r;
            `OFF_RESULT_MIRROR: rdata_nxt[0]   = cmp_result_bit_r;
            `OFF_IRQ_FLAG:      rdata_nxt[0]   = flag_r;
            `OFF_SYS_CTRL:      rdata_nxt[5:0] = sys_ctrl_r;
            `OFF_STATUS:        rdata_nxt[1:0] = {tclk_stable_r, raw_stable_r};
            default:            slverr_nxt     = wr_setup | rd_setup;
        endcase
    end

    // Output conditioning, edge detection and consumer outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_result_bit_r  <= 1'b0;
            result_prev_r     <= 1'b0;
            flag_r            <= 1'b0;
            sync_hold_r       <= 1'b0;
            cmp_irq_flag      <= 1'b0;
            wake_req          <= 1'b0;
            analog_on         <= 1'b0;
            hysteresis_on     <= 1'b0;
            plus_src_on       <= {`SRC_W{1'b0}};
            minus_src_on      <= {`SRC_W{1'b0}};
            gate_out          <= 1'b0;
            pin_out           <= 1'b0;
            conv_trigger      <= 1'b0;
            even_timer_reset  <= 1'b0;
            waveform_shutdown <= 1'b0;
        end else begin
            cmp_result_bit_r <= result_now;
            result_prev_r    <= result_now;
            // Hardware set has priority over the software clear
            flag_r       <= irq_evt | (flag_r & ~flag_clr);
            cmp_irq_flag <= irq_evt | (flag_r & ~flag_clr);
            wake_req     <= irq_evt;
            analog_on     <= cmp_on_r;
            hysteresis_on <= hyst_r;
            plus_src_on   <= plus_decode(plus_input_sel_r, cmp_on_r);
            minus_src_on  <= minus_decode(minus_input_sel_r, cmp_on_r);
            if (tclk_fall & ~sync_stall)
                sync_hold_r <= result_now;
            // Async mode still costs one flop, since outputs must be registered
            gate_out <= sync_r ? sync_hold_r : result_now;
            pin_out  <= sync_r ? sync_hold_r : result_now;
            conv_trigger      <= rise_evt & sys_ctrl_r[`SC_TRIG_SEL_BIT];
            even_timer_reset  <= rise_evt & sys_ctrl_r[`SC_RST_SEL_BIT];
            waveform_shutdown <= result_now & sys_ctrl_r[`SC_SHDN_BIT];
        end
    end

endmodule // cmp_ctrl

// ---- verilog/cmp_ctrl_consts.vh ----
// Register offsets, field positions, reset values and codes for the comparator control block
`ifndef CMP_CTRL_CONSTS_VH
`define CMP_CTRL_CONSTS_VH
// Register byte addresses on the APB
`define OFF_CTRL_A        12'h000
`define OFF_CTRL_B        12'h004
`define OFF_MINUS_SEL     12'h008
`define OFF_PLUS_SEL      12'h00c
`define OFF_RESULT_MIRROR 12'h010
`define OFF_IRQ_FLAG      12'h014
`define OFF_SYS_CTRL      12'h018
`define OFF_STATUS        12'h01c
// Control register A fields
`define CA_ON_BIT         7
`define CA_RESULT_BIT     6
`define CA_INVERT_BIT     4
`define CA_HYST_BIT       1
`define CA_SYNC_BIT       0
// Control register B fields
`define CB_RISE_BIT       1
`define CB_FALL_BIT       0
// System control fields
`define SC_PRESCALE_BIT   0
`define SC_SLEEP_BIT      1
`define SC_TMR_SYSCLK_BIT 2
`define SC_TRIG_SEL_BIT   3
`define SC_RST_SEL_BIT    4
`define SC_SHDN_BIT       5
// Reset values
`define CTRL_A_RST        8'h00
`define CTRL_B_RST        2'h0
`define SEL_RST           3'h0
`define SYS_CTRL_RST      6'h00
// Plus selector codes
`define PSEL_PIN0         3'h0
`define PSEL_PIN1         3'h1
`define PSEL_DAC          3'h5
`define PSEL_REF2         3'h6
`define PSEL_GND          3'h7
// Minus selector codes
`define NSEL_PIN0         3'h0
`define NSEL_PIN1         3'h1
`define NSEL_PIN2         3'h2
`define NSEL_PIN3         3'h3
`define NSEL_REF2         3'h6
`define NSEL_GND          3'h7
// Source enable vector width: pin0..pin3, dac, ref2, gnd
`define SRC_W             7
`define SRC_PIN0          0
`define SRC_DAC           4
`define SRC_REF2          5
`define SRC_GND           6
`endif

// ---- dv/cmp_ctrl_assertions.sv ----
// Port-level checker for the comparator control block
`timescale 1ns/1ns
`include "cmp_ctrl_consts.vh"
module cmp_ctrl_assertions (
    // Clock, reset and APB
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    // Block outputs
    input wire logic              analog_on,
    input wire logic [`SRC_W-1:0] plus_src_on,
    input wire logic [`SRC_W-1:0] minus_src_on,
    input wire logic              conv_trigger,
    input wire logic              cmp_irq_flag,
    input wire logic              wake_req
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr = psel && penable && pwrite;
    AST_APB_READY: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    AST_ON_SET: assert property (wr && paddr == `OFF_CTRL_A && pwdata[7] |-> ##[1:2] analog_on)
        else $error("core not powered after enable");
    AST_ON_CLR: assert property (wr && paddr == `OFF_CTRL_A && !pwdata[7] |-> ##[1:2] !analog_on)
        else $error("core still powered after disable");
    AST_OFF_SRC: assert property (!analog_on && !$past(analog_on) |-> !(plus_src_on | minus_src_on))
        else $error("source connected while off");
    AST_PLUS_CODES: assert property ($onehot0(plus_src_on) && plus_src_on[3:2] == 2'b00)
        else $error("bad plus source vector");
    AST_MINUS_CODES: assert property ($onehot0(minus_src_on) && !minus_src_on[`SRC_DAC])
        else $error("bad minus source vector");
    AST_FLAG_CLR: assert property ($fell(cmp_irq_flag) |-> $past(wr && paddr == `OFF_IRQ_FLAG && pwdata[0]))
        else $error("flag fell without a clear");
    AST_FLAG_WAKE: assert property ($rose(cmp_irq_flag) |-> wake_req || $past(wake_req))
        else $error("flag set without wake pulse");
    AST_TRIG_PULSE: assert property (conv_trigger |=> !conv_trigger)
        else $error("trigger longer than one cycle");
endmodule // cmp_ctrl_assertions
bind cmp_ctrl cmp_ctrl_assertions chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .analog_on, .plus_src_on, .minus_src_on, .conv_trigger,
    .cmp_irq_flag, .wake_req);

// ---- dv/cmp_analog_model.sv ----
// Behavioural analog core and timer clock source
`timescale 1ns/1ns
module cmp_analog_model (
    // Control
    input  wire logic pclk,
    input  wire logic analog_on,
    input  wire logic plus_above,
    input  wire logic tmr_run,
    // To the block
    output logic      analog_raw,
    output logic      tmr_clk,
    output logic      tmr_clk_pre
);
    // An unpowered core gives no usable level, so it toggles to expose a missing force
    always @(posedge pclk)
        analog_raw <= analog_on ? plus_above : ~analog_raw;
    // Timer clocks stand still unless the bench runs them
    initial begin
        analog_raw = 1'b0;
        tmr_clk = 1'b0;
        tmr_clk_pre = 1'b0;
        forever begin
            #70;
            if (tmr_run && tmr_clk) tmr_clk_pre = ~tmr_clk_pre;
            if (tmr_run) tmr_clk = ~tmr_clk;
        end
    end
endmodule // cmp_analog_model

// ---- dv/tb_top.sv ----
// Self-checking bench for the comparator control block
`timescale 1ns/1ns
`include "cmp_ctrl_consts.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, lvl = 0, trun = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, er, analog_raw, analog_on, hysteresis_on, tclk, tclk_pre;
    logic gate_out, pin_out, conv_trigger, even_timer_reset, waveform_shutdown;
    logic cmp_irq_flag, wake_req;
    logic [`SRC_W-1:0] plus_src_on, minus_src_on;
    int n_errors = 0, total_checks = 0, n_trig = 0, n_rst = 0;
    cmp_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .analog_raw, .analog_on, .hysteresis_on, .plus_src_on,
        .minus_src_on, .timer_clk_in(tclk), .timer_clk_pre_in(tclk_pre), .gate_out, .pin_out,
        .conv_trigger, .even_timer_reset, .waveform_shutdown, .cmp_irq_flag, .wake_req);
    cmp_analog_model core (.pclk, .analog_on, .plus_above(lvl), .tmr_run(trun), .analog_raw,
        .tmr_clk(tclk), .tmr_clk_pre(tclk_pre));
    initial forever #10 pclk = ~pclk;
    always @(posedge pclk) begin
        n_trig <= n_trig + conv_trigger;
        n_rst <= n_rst + even_timer_reset;
    end
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Look at ready where it is settled; the transfer ends at the next rising edge
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            n_errors++;
            summarize();
        end
    endtask
    task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rd[7:0])
    endtask
    task automatic t_pol;
        logic e;
        for (int i = 0; i < 8; i++) begin
            lvl <= i[0];
            apb(1'b1, `OFF_CTRL_A, {i[2], 2'b00, i[1], 2'b00, ~i[1], 1'b0});
            repeat (8) @(posedge pclk);
            e = (i[2] & i[0]) ^ i[1];
            rchk("result", `OFF_CTRL_A, {i[2], e, 1'b0, i[1], 2'b00, ~i[1], 1'b0});
            rchk("mirror", `OFF_RESULT_MIRROR, {7'h00, e});
            `CHK("gate", e, gate_out)
            `CHK("pin", e, pin_out)
            `CHK("hyst", ~i[1], hysteresis_on)
        end
    endtask
    task automatic t_sel;
        logic [6:0] ep, en;
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, `OFF_CTRL_A, {c[3], 7'h00});
            apb(1'b1, `OFF_PLUS_SEL, c[2:0]);
            apb(1'b1, `OFF_MINUS_SEL, c[2:0]);
            ep = c[2:0] < 2 ? 7'h01 << c[2:0] : c[2:0] > 4 ? 7'h01 << (c[2:0] - 1) : 7'h00;
            en = c[2:0] < 4 ? 7'h01 << c[2:0] : c[2:0] > 5 ? 7'h01 << (c[2:0] - 1) : 7'h00;
            rchk("plus code", `OFF_PLUS_SEL, c[2:0]);
            `CHK("plus src", c[3] ? ep : 7'h00, plus_src_on)
            `CHK("minus src", c[3] ? en : 7'h00, minus_src_on)
        end
    endtask
    task automatic t_sync;
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, `OFF_SYS_CTRL, p);
            lvl <= 1'b0;
            apb(1'b1, `OFF_CTRL_A, 32'h81);
            trun <= 1'b1;
            repeat (40) @(posedge pclk);
            trun <= 1'b0;
            lvl <= 1'b1;
            repeat (20) @(posedge pclk);
            `CHK("sync hold", 1'b0, gate_out)
            rchk("sync result", `OFF_CTRL_A, 8'hc1);
            trun <= 1'b1;
            repeat (40) @(posedge pclk);
            trun <= 1'b0;
            `CHK("sync follow", 1'b1, pin_out)
        end
    endtask
    task automatic t_irq;
        int t0, r0;
        apb(1'b1, `OFF_CTRL_A, 32'h0);
        apb(1'b1, `OFF_SYS_CTRL, 32'h38);
        repeat (8) @(posedge pclk);
        apb(1'b1, `OFF_IRQ_FLAG, 32'h1);
        apb(1'b1, `OFF_CTRL_B, 32'h3);
        t0 = n_trig;
        r0 = n_rst;
        apb(1'b1, `OFF_CTRL_A, 32'h10);
        repeat (8) @(posedge pclk);
        rchk("flag on rise", `OFF_IRQ_FLAG, 8'h01);
        `CHK("shutdown", 1'b1, waveform_shutdown)
        `CHK("conv trig", 1, n_trig - t0)
        `CHK("timer reset", 1, n_rst - r0)
        apb(1'b1, `OFF_IRQ_FLAG, 32'h1);
        rchk("flag clear", `OFF_IRQ_FLAG, 8'h00);
        apb(1'b1, `OFF_CTRL_B, 32'h2);
        apb(1'b1, `OFF_CTRL_A, 32'h0);
        repeat (8) @(posedge pclk);
        `CHK("fall masked", 1'b0, cmp_irq_flag)
        `CHK("shutdown off", 1'b0, waveform_shutdown)
        apb(1'b1, `OFF_CTRL_B, 32'h1);
        apb(1'b1, `OFF_CTRL_A, 32'h10);
        repeat (8) @(posedge pclk);
        `CHK("rise masked", 1'b0, cmp_irq_flag)
        apb(1'b1, `OFF_CTRL_A, 32'h0);
        repeat (8) @(posedge pclk);
        `CHK("fall flag", 1'b1, cmp_irq_flag)
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rchk("ctrl a reset", `OFF_CTRL_A, 8'h00);
        apb(1'b0, 12'h020, 32'h0);
        `CHK("unmapped", 1'b1, er)
        t_pol();
        t_sel();
        t_sync();
        t_irq();
        summarize();
    end
endmodule // tb_top
